//--- onscreen_text_unit.sv
// On-screen character display: paged core access, line walker, sync-gated oscillator
`timescale 1ns/1ps
module onscreen_text_unit
    import text_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] core_addr,
    input wire logic [7:0] core_wdata,
    input wire logic core_we,
    input wire logic core_re,
    output logic [7:0] core_rdata,
    input wire logic vsync,
    input wire logic hsync,
    input wire logic glyph_pixel,
    output logic [5:0] glyph_code,
    output logic glyph_bank,
    output logic [4:0] glyph_row,
    output logic [2:0] glyph_col,
    output logic red,
    output logic green,
    output logic blue,
    output logic blank,
    output logic osc_run
);
    import text_unit_pkg::*;

    logic [6:0] ram [0:79];
    logic [7:0] page;
    logic [7:0] vstart_setup, hstart_setup, vspace_setup;
    logic [7:0] word_gap_and_size, background_setup;
    logic glyph_bank_bit, display_master_on;
    logic vsync_q, hsync_q, vsync_rise, hsync_rise;
    logic in_window, pg_low, pg_high, locked, ram_hit, master_hit, bank_hit;
    logic [6:0] ram_idx;
    logic [5:0] off;

    assign vsync_rise = vsync & ~vsync_q;
    assign hsync_rise = hsync & ~hsync_q;
    assign off = core_addr[5:0];
    assign in_window = core_addr < WINDOW_END;
    assign pg_low = page == PAGE_LINES_1_4;
    assign pg_high = page == PAGE_LINE_5;
    assign locked = display_master_on | osc_run;
    assign ram_hit = in_window & (pg_low | (pg_high & off < OFF_VSTART));
    // Line 5 sits after the 64 entries of lines 1-4
    assign ram_idx = pg_low ? {1'b0, off} : {3'b100, off[3:0]};
    assign master_hit = in_window & pg_high & off == OFF_MASTER;
    assign bank_hit = core_addr == BANK_REG_ADDR;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vsync_q <= 1'b0;
            hsync_q <= 1'b0;
        end else begin
            vsync_q <= vsync;
            hsync_q <= hsync;
        end
    end

    // RAM has no reset; contents are undefined until software loads them
    always_ff @(posedge clk) begin
        if (core_we && ram_hit && !locked) begin
            ram[ram_idx] <= core_wdata[6:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page <= REG_RESET;
            vstart_setup <= REG_RESET;
            hstart_setup <= REG_RESET;
            vspace_setup <= REG_RESET;
            word_gap_and_size <= REG_RESET;
            background_setup <= REG_RESET;
            glyph_bank_bit <= 1'b0;
        end else if (core_we) begin
            if (core_addr == PAGE_REG_ADDR) begin
                page <= core_wdata;
            end
            if (bank_hit && !locked) begin
                glyph_bank_bit <= core_wdata[0];
            end
            if (in_window && pg_high && !locked) begin
                unique case (off)
                    OFF_VSTART: vstart_setup <= core_wdata;
                    OFF_HSTART: hstart_setup <= core_wdata;
                    OFF_VSPACE: vspace_setup <= core_wdata;
                    OFF_WORD_GAP: word_gap_and_size <= core_wdata;
                    OFF_BACKGROUND: background_setup <= core_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Master enable and oscillator: start waits for a sync, stop does not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            display_master_on <= 1'b0;
            osc_run <= 1'b0;
        end else begin
            if (core_we && master_hit) begin
                display_master_on <= core_wdata[0];
            end
            if (core_we && master_hit && !core_wdata[0]) begin
                osc_run <= 1'b0;
            end else if (display_master_on && vsync_rise) begin
                osc_run <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rdata <= REG_RESET;
        end else if (core_re) begin
            core_rdata <= REG_RESET;
            if (core_addr == PORT_REG_ADDR) begin
                core_rdata[VSYNC_PORT_BIT] <= ~vsync;
            end else if (core_addr == PAGE_REG_ADDR) begin
                core_rdata <= page;
            end else if (bank_hit) begin
                core_rdata <= {7'h00, glyph_bank_bit};
            end else if (!locked && ram_hit) begin
                core_rdata <= {1'b0, ram[ram_idx]};
            end else if (!locked && in_window && pg_high) begin
                unique case (off)
                    OFF_VSTART: core_rdata <= vstart_setup;
                    OFF_HSTART: core_rdata <= hstart_setup;
                    OFF_VSPACE: core_rdata <= vspace_setup;
                    OFF_WORD_GAP: core_rdata <= word_gap_and_size;
                    OFF_BACKGROUND: core_rdata <= background_setup;
                    default: core_rdata <= REG_RESET;
                endcase
            end
        end
    end

    // Display-side walker
    logic [2:0] row;
    logic [3:0] col;
    logic [6:0] fmt, entry;
    logic [2:0] mult;
    logic [6:0] height;
    logic [9:0] vline;
    logic [6:0] rline;
    logic [7:0] gap_cnt;
    logic v_active, in_gap;
    logic [1:0] vsub, csub;
    logic [4:0] grow;
    logic [2:0] gcol;
    hstate_t hstate;
    logic half;
    logic [7:0] hcnt;
    logic [8:0] cdot, cell_dots;
    logic [3:0] bar_cnt;
    logic is_space, sbd, bg_on;
    logic [2:0] bg_colour;
    colour_t a_colour;
    logic a_bg, a_vis;

    assign fmt = ram[{row, 4'h0}];
    assign entry = ram[{row, col}];
    assign is_space = entry[SPC_MARK_BIT];
    assign sbd = hstart_setup[SPACE_BLANK_BIT];

    // Size multiplier from the global pair and the format size bit
    always_comb begin
        unique case ({word_gap_and_size[7:6], fmt[FMT_SIZE_BIT]})
            3'b000, 3'b010: mult = 3'd1;
            3'b001, 3'b100, 3'b110: mult = 3'd2;
            3'b011, 3'b101: mult = 3'd3;
            default: mult = 3'd4;
        endcase
    end
    assign height = 7'(CELL_LINES * {4'h0, mult});
    // Extra gap is (1+field) dots per size step
    assign cell_dots = 9'(CELL_DOTS * {6'h00, mult})
        + ((is_space && entry[SPC_GAP_BIT])
           ? 9'(({3'b000, word_gap_and_size[5:0]} + 9'd1) * {6'h00, mult}) : 9'd0);
    assign bg_on = a_bg ? background_setup[BG1_ON_BIT] : background_setup[BG0_ON_BIT];
    assign bg_colour = a_bg ? background_setup[BG1_COLOUR_LSB +: 3]
                            : background_setup[BG0_COLOUR_LSB +: 3];

    // Vertical walk over scan lines since vertical sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vline <= 10'h000;
            row <= 3'h0;
            rline <= 7'h00;
            gap_cnt <= 8'h00;
            v_active <= 1'b0;
            in_gap <= 1'b0;
            vsub <= 2'h0;
            grow <= 5'h00;
        end else if (vsync_rise) begin
            vline <= 10'h000;
            row <= 3'h0;
            v_active <= 1'b0;
            in_gap <= 1'b0;
        end else if (hsync_rise && osc_run) begin
            vline <= vline + 10'h001;
            if (!v_active && row == 3'h0 && vline + 10'h001 == {2'b00, vstart_setup[5:0], 2'b00}) begin
                v_active <= 1'b1;
                rline <= 7'h00;
                vsub <= 2'h0;
                grow <= 5'h00;
            end else if (v_active && in_gap) begin
                gap_cnt <= gap_cnt - 8'h01;
                if (gap_cnt == 8'h01) begin
                    in_gap <= 1'b0;
                    row <= row + 3'h1;
                    v_active <= row != LAST_LINE;
                end
            end else if (v_active) begin
                if (rline == height - 7'h01) begin
                    rline <= 7'h00;
                    vsub <= 2'h0;
                    grow <= 5'h00;
                    // Zero spacing is illegal, so treat it as no gap
                    if (fmt[FMT_LGAP_BIT] && vspace_setup[5:0] != 6'h00) begin
                        in_gap <= 1'b1;
                        gap_cnt <= {vspace_setup[5:0], 2'b00};
                    end else begin
                        row <= row + 3'h1;
                        v_active <= row != LAST_LINE;
                    end
                end else begin
                    rline <= rline + 7'h01;
                    vsub <= (vsub == 2'(mult - 3'h1)) ? 2'h0 : vsub + 2'h1;
                    if (vsub == 2'(mult - 3'h1)) begin
                        grow <= grow + 5'h01;
                    end
                end
            end
        end
    end

    // Horizontal walk; one dot period is two clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hstate <= H_IDLE;
            half <= 1'b0;
            hcnt <= 8'h00;
            col <= 4'h0;
            cdot <= 9'h000;
            csub <= 2'h0;
            gcol <= 3'h0;
            bar_cnt <= 4'h0;
            a_colour <= COL_BLACK;
            a_bg <= 1'b0;
            a_vis <= 1'b0;
        end else if (!osc_run) begin
            hstate <= H_IDLE;
        end else if (hsync_rise) begin
            hstate <= (v_active && !in_gap) ? H_WAIT : H_IDLE;
            half <= 1'b0;
            hcnt <= 8'h00;
            col <= 4'h0;
        end else begin
            half <= ~half;
            unique case (hstate)
                H_IDLE: ;
                H_WAIT: if (half) begin
                    hcnt <= hcnt + 8'h01;
                    if (hcnt == HSTART_BASE + {2'b00, hstart_setup[5:0]}) begin
                        hstate <= H_CELL;
                        col <= 4'h1;
                        cdot <= 9'h000;
                        csub <= 2'h0;
                        gcol <= 3'h0;
                        a_colour <= colour_t'(fmt[FMT_COLOUR_LSB +: 3]);
                        a_bg <= fmt[FMT_BG_BIT];
                        a_vis <= fmt[FMT_VIS_BIT];
                    end
                end
                H_CELL: if (half) begin
                    cdot <= cdot + 9'h001;
                    csub <= (csub == 2'(mult - 3'h1)) ? 2'h0 : csub + 2'h1;
                    if (csub == 2'(mult - 3'h1)) begin
                        gcol <= gcol + 3'h1;
                    end
                    if (cdot == cell_dots - 9'h001) begin
                        cdot <= 9'h000;
                        csub <= 2'h0;
                        gcol <= 3'h0;
                        if (is_space) begin
                            a_colour <= colour_t'(entry[SPC_COLOUR_LSB +: 3]);
                            a_bg <= entry[SPC_BG_BIT];
                            a_vis <= entry[SPC_VIS_BIT];
                        end
                        if (col == LAST_COL) begin
                            hstate <= (is_space && !fmt[FMT_SIZE_BIT] && sbd) ? H_BAR : H_IDLE;
                            bar_cnt <= BAR_DOTS;
                        end else begin
                            col <= col + 4'h1;
                        end
                    end
                end
                H_BAR: if (half) begin
                    bar_cnt <= bar_cnt - 4'h1;
                    if (bar_cnt == 4'h1) begin
                        hstate <= H_IDLE;
                    end
                end
                default: hstate <= H_IDLE;
            endcase
        end
    end

    // Video outputs; glyph_pixel is expected one clock after the glyph address
    logic show_fg, show_bg, show_bar;
    assign show_fg = hstate == H_CELL && display_master_on && a_vis && !is_space
        && glyph_pixel;
    assign show_bg = hstate == H_CELL && display_master_on && a_vis && bg_on
        && !(is_space && sbd);
    assign show_bar = hstate == H_BAR && display_master_on && bg_on;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {red, green, blue} <= COL_BLACK;
            blank <= 1'b0;
            glyph_code <= 6'h00;
            glyph_bank <= 1'b0;
            glyph_row <= 5'h00;
            glyph_col <= 3'h0;
        end else begin
            if (show_fg) begin
                {red, green, blue} <= a_colour;
            end else if (show_bg || show_bar) begin
                {red, green, blue} <= bg_colour;
            end else begin
                {red, green, blue} <= COL_BLACK;
            end
            blank <= show_fg | show_bg | show_bar | vspace_setup[SCREEN_BLANK_BIT];
            glyph_code <= entry[5:0];
            glyph_bank <= glyph_bank_bit;
            glyph_row <= grow;
            glyph_col <= gcol;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_master_clear;
        core_we && master_hit && !core_wdata[0];
    endsequence
    sequence s_last_space_cell;
        hstate == H_CELL && half && col == LAST_COL && cdot == cell_dots - 9'h001
        && is_space && !fmt[FMT_SIZE_BIT] && sbd;
    endsequence

    a_osc_stop: assert property (s_master_clear |=> !osc_run && !display_master_on)
        else $error("oscillator still running after enable cleared");
    a_osc_start_sync: assert property ($rose(osc_run) |-> $past(vsync_rise))
        else $error("oscillator started without vertical sync");
    a_osc_waits_frame: assert property (
        display_master_on && !osc_run && !vsync_rise
        && !(core_we && master_hit && !core_wdata[0]) |=> !osc_run)
        else $error("oscillator started before the next frame");
    a_reg_lock: assert property (
        core_we && in_window && pg_high && locked && off != OFF_MASTER
        |=> $stable(word_gap_and_size) && $stable(background_setup))
        else $error("control register changed while locked");
    a_bank_lock: assert property (core_we && bank_hit && locked |=> $stable(glyph_bank_bit))
        else $error("bank bit changed while display on");
    a_port_vsync: assert property (
        core_re && core_addr == PORT_REG_ADDR |=> core_rdata[VSYNC_PORT_BIT] == !$past(vsync))
        else $error("port bit does not show inverted vertical sync");
    a_ram_hidden: assert property (core_re && ram_hit && locked |=> core_rdata == REG_RESET)
        else $error("display RAM readable while display on");
    a_col_range: assert property (hstate == H_CELL |-> col != 4'h0)
        else $error("format column reached the screen");
    a_end_bar: assert property (s_last_space_cell |=> hstate == H_BAR [*2])
        else $error("end-of-line bar missing");
    a_size_max: assert property ({word_gap_and_size[7:6], fmt[FMT_SIZE_BIT]} == 3'b111
        |-> height == 7'd72)
        else $error("largest size is not 72 lines");
    a_fg_colour: assert property (show_fg |=> {red, green, blue} == $past(a_colour) && blank)
        else $error("glyph dot not drawn in word colour");
endmodule

//--- test_onscreen_text_unit.sv
// Self-checking bench for the on-screen text unit with a mirror model
`timescale 1ns/1ps
module test_onscreen_text_unit;
    import text_unit_pkg::*;
    localparam int FRAME = 256 * 32;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] core_addr = 8'h00;
    logic [7:0] core_wdata = 8'h00;
    logic core_we = 1'b0;
    logic core_re = 1'b0;
    logic [7:0] core_rdata;
    logic vsync, hsync, glyph_pixel, glyph_bank, red, green, blue, blank, osc_run;
    logic [5:0] glyph_code;
    logic [4:0] glyph_row;
    logic [2:0] glyph_col;
    int mismatches = 0;
    int comparisons = 0;
    int ram [80];
    logic [7:0] creg [5];
    logic [7:0] page_m;
    logic bank_m, master_m, exp_osc, vs_prev;
    wire lock = master_m | exp_osc;
    logic bank_d, master_d, vsb_d;
    logic video_on = 1'b0;
    int n_fg = 0;
    int n_bg = 0;
    int n_bar = 0;
    wire [3:0] vid = {blank, red, green, blue};
    wire pos_ok = glyph_col <= 3'd5 && glyph_row <= 5'd17;
    always #2 clk = ~clk;
    onscreen_text_unit onscreen_text_unit_inst (.clk(clk), .rst_n(rst_n),
        .core_addr(core_addr), .core_wdata(core_wdata), .core_we(core_we),
        .core_re(core_re), .core_rdata(core_rdata), .vsync(vsync), .hsync(hsync),
        .glyph_pixel(glyph_pixel), .glyph_code(glyph_code), .glyph_bank(glyph_bank),
        .glyph_row(glyph_row), .glyph_col(glyph_col), .red(red), .green(green),
        .blue(blue), .blank(blank), .osc_run(osc_run));
    tv_sync_model tv_sync_model_inst (.clk(clk), .rst_n(rst_n), .glyph_code(glyph_code),
        .glyph_bank(glyph_bank), .glyph_row(glyph_row), .glyph_col(glyph_col),
        .glyph_pixel(glyph_pixel), .vsync(vsync), .hsync(hsync));
    // Mirror model, updated on the same edges that take core requests
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_m <= 8'h00;
            bank_m <= 1'b0;
            master_m <= 1'b0;
            exp_osc <= 1'b0;
            vs_prev <= 1'b0;
            bank_d <= 1'b0;
            master_d <= 1'b0;
            vsb_d <= 1'b0;
            foreach (creg[i]) creg[i] <= 8'h00;
        end else begin
            vs_prev <= vsync;
            // Video outputs lag the model state by one edge
            bank_d <= bank_m;
            master_d <= master_m;
            vsb_d <= creg[2][SCREEN_BLANK_BIT];
            if (master_m && vsync && !vs_prev) exp_osc <= 1'b1;
            if (core_we && core_addr == PAGE_REG_ADDR) page_m <= core_wdata;
            if (core_we && core_addr == BANK_REG_ADDR && !lock) bank_m <= core_wdata[0];
            if (core_we && core_addr < WINDOW_END && !lock) begin
                if (page_m == PAGE_LINES_1_4) ram[core_addr] <= int'(core_wdata[6:0]);
                else if (page_m == PAGE_LINE_5 && core_addr < 8'h10) begin
                    ram[64 + core_addr] <= int'(core_wdata[6:0]);
                end else if (page_m == PAGE_LINE_5 && core_addr < 8'h15) begin
                    creg[core_addr - 8'h10] <= core_wdata;
                end
            end
            if (core_we && page_m == PAGE_LINE_5 && core_addr == 8'h17) begin
                master_m <= core_wdata[0];
                if (!core_wdata[0]) exp_osc <= 1'b0;
            end
        end
    end
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == PAGE_REG_ADDR) return page_m;
        if (a == PORT_REG_ADDR) return {3'h0, ~vs_prev, 4'h0};
        if (a == BANK_REG_ADDR) return {7'h00, bank_m};
        if (a >= WINDOW_END || lock) return 8'h00;
        if (page_m == PAGE_LINES_1_4) return 8'(ram[a]);
        if (page_m != PAGE_LINE_5 || a > 8'h14) return 8'h00;
        return (a < 8'h10) ? 8'(ram[64 + a]) : creg[a - 8'h10];
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    always @(negedge clk) begin
        if (rst_n) begin
            check("osc_run", {7'h00, exp_osc}, {7'h00, osc_run});
            check("glyph_bank", {7'h00, bank_d}, {7'h00, glyph_bank});
            if (!master_d) check("video off", {4'h0, vsb_d, 3'h0}, {4'h0, vid});
            if (video_on && vid[2:0] != 3'h0) begin
                check("blank", 8'h01, {7'h00, blank});
                check("glyph pos", 8'h01, {7'h00, pos_ok});
                case (vid[2:0])
                    3'h7: n_fg++;
                    3'h1: n_bg++;
                    3'h4: n_bar++;
                    default: check("colour", 8'h07, {5'h00, vid[2:0]});
                endcase
            end
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        core_addr = a;
        core_wdata = d;
        core_we = 1'b1;
        @(posedge clk);
        #1;
        core_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input string what);
        @(posedge clk);
        #1;
        core_addr = a;
        core_re = 1'b1;
        @(posedge clk);
        #1;
        core_re = 1'b0;
        check(what, exp_rd(a) & m, core_rdata & m);
    endtask
    // Whole display RAM, both pages; leaves the second page selected
    // Pattern: white visible format, plain glyphs, space in column 15
    task automatic sweep(input bit reading, input bit pattern = 1'b0);
        for (int a = 0; a < 80; a++) begin
            logic [7:0] d;
            d = 8'($urandom);
            if (pattern) d = (a % 16 == 15) ? 8'h46 : d & 8'h3F;
            if (pattern && a % 16 == 0) d = 8'h74;
            if (a % 64 == 0) wr(PAGE_REG_ADDR, a < 64 ? PAGE_LINES_1_4 : PAGE_LINE_5);
            if (reading) rd(8'(a % 64), 8'hFF, "display ram");
            else wr(8'(a % 64), d);
        end
    endtask
    task automatic ctl_sweep(input bit reading);
        for (int a = 16; a < 25; a++) begin
            if (reading) rd(8'(a), 8'hFF, "control");
            else if (a < 21) wr(8'(a), 8'($urandom) & (a < 19 ? 8'h7F : 8'hFF));
        end
        if (reading) rd(BANK_REG_ADDR, 8'h01, "bank");
        else wr(BANK_REG_ADDR, 8'($urandom));
    endtask
    task automatic wait_sig(input bit osc, input logic lvl);
        int n;
        n = 0;
        while ((osc ? osc_run : vsync) !== lvl) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 2 * FRAME) begin
                mismatches++;
                $display("Error wait expected %b seen timeout", lvl);
                wrap_up();
            end
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        int seed;
        seed = $urandom(34);
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        wr(PAGE_REG_ADDR, PAGE_LINE_5);
        ctl_sweep(1'b1);
        $display("Test reset values done");
        sweep(1'b0);
        sweep(1'b1);
        ctl_sweep(1'b0);
        ctl_sweep(1'b1);
        rd(8'h50, 8'hFF, "unmapped");
        wr(PAGE_REG_ADDR, 8'h00);
        rd(8'h05, 8'hFF, "no page");
        rd(PAGE_REG_ADDR, 8'hFF, "page");
        $display("Test ram and controls done");
        wait_sig(1'b0, 1'b1);
        rd(PORT_REG_ADDR, 8'h10, "vsync port");
        wait_sig(1'b0, 1'b0);
        rd(PORT_REG_ADDR, 8'h10, "vsync port");
        $display("Test vsync port done");
        wr(PAGE_REG_ADDR, PAGE_LINE_5);
        wr({2'b00, OFF_MASTER}, 8'h01);
        sweep(1'b0);
        ctl_sweep(1'b0);
        sweep(1'b1);
        wait_sig(1'b1, 1'b1);
        wr({2'b00, OFF_MASTER}, 8'h00);
        sweep(1'b1);
        ctl_sweep(1'b1);
        $display("Test lock done");
        wait_sig(1'b0, 1'b1);
        wait_sig(1'b0, 1'b0);
        wr({2'b00, OFF_MASTER}, 8'h01);
        wait_sig(1'b1, 1'b1);
        wr({2'b00, OFF_MASTER}, 8'h00);
        repeat (4) @(posedge clk);
        $display("Test late enable done");
        wait_sig(1'b0, 1'b0);
        wait_sig(1'b0, 1'b1);
        wr({2'b00, OFF_MASTER}, 8'h00);
        sweep(1'b0, 1'b1);
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h40);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h00);
        wr(8'h14, 8'hC9);
        wr({2'b00, OFF_MASTER}, 8'h01);
        check("flyback", 8'h01, {7'h00, vsync});
        wait_sig(1'b1, 1'b1);
        video_on = 1'b1;
        repeat (FRAME) @(posedge clk);
        video_on = 1'b0;
        check("fg dots", 8'h01, {7'h00, n_fg > 0});
        check("word background", 8'h01, {7'h00, n_bg > 0});
        check("end bar", 8'h01, {7'h00, n_bar > 0});
        $display("Test video done");
        wrap_up();
    end
endmodule

//--- text_unit_pkg.sv
// Shared constants for the on-screen character display controller
package text_unit_pkg;
    // Core data-space addresses outside the paged window, the window end and the two page values
    localparam logic [7:0] PAGE_REG_ADDR = 8'hE8;
    localparam logic [7:0] PORT_REG_ADDR = 8'hE4;
    localparam logic [7:0] BANK_REG_ADDR = 8'hED;
    localparam logic [7:0] WINDOW_END = 8'h40;
    localparam logic [7:0] PAGE_LINES_1_4 = 8'h20;
    localparam logic [7:0] PAGE_LINE_5 = 8'h40;
    // Offsets inside the second page
    localparam logic [5:0] OFF_VSTART = 6'h10;
    localparam logic [5:0] OFF_HSTART = 6'h11;
    localparam logic [5:0] OFF_VSPACE = 6'h12;
    localparam logic [5:0] OFF_WORD_GAP = 6'h13;
    localparam logic [5:0] OFF_BACKGROUND = 6'h14;
    localparam logic [5:0] OFF_MASTER = 6'h17;
    localparam int VSYNC_PORT_BIT = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Format entry (column 0) fields
    localparam int FMT_COLOUR_LSB = 4;
    localparam int FMT_BG_BIT = 3;
    localparam int FMT_VIS_BIT = 2;
    localparam int FMT_SIZE_BIT = 1;
    localparam int FMT_LGAP_BIT = 0;
    // Space entry fields; plain glyphs keep bit 6 at zero
    localparam int SPC_MARK_BIT = 6;
    localparam int SPC_COLOUR_LSB = 3;
    localparam int SPC_BG_BIT = 2;
    localparam int SPC_VIS_BIT = 1;
    localparam int SPC_GAP_BIT = 0;
    // Background register fields, then the blank bits of the vertical-spacing and horizontal-start registers
    localparam int BG1_ON_BIT = 7;
    localparam int BG1_COLOUR_LSB = 4;
    localparam int BG0_ON_BIT = 3;
    localparam int BG0_COLOUR_LSB = 0;
    localparam int SCREEN_BLANK_BIT = 6;
    localparam int SPACE_BLANK_BIT = 6;
    // Geometry and timing counts
    localparam logic [6:0] CELL_LINES = 7'd18;
    localparam logic [8:0] CELL_DOTS = 9'd6;
    localparam logic [7:0] HSTART_BASE = 8'd10;
    localparam logic [3:0] BAR_DOTS = 4'd6;
    localparam logic [2:0] LAST_LINE = 3'd4;
    localparam logic [3:0] LAST_COL = 4'd15;
    localparam int OSC_PERIOD_NS = 4;
    localparam int DOT_PERIOD_NS = 2 * OSC_PERIOD_NS;
    localparam int CLK_PER_DOT = DOT_PERIOD_NS / OSC_PERIOD_NS;
    typedef enum logic [2:0] {
        COL_BLACK = 3'h0, COL_BLUE = 3'h1, COL_GREEN = 3'h2, COL_CYAN = 3'h3,
        COL_RED = 3'h4, COL_MAGENTA = 3'h5, COL_YELLOW = 3'h6, COL_WHITE = 3'h7
    } colour_t;
    typedef enum logic [3:0] {
        H_IDLE = 4'h1, H_WAIT = 4'h2, H_CELL = 4'h4, H_BAR = 4'h8
    } hstate_t;
endpackage

//--- tv_sync_model.sv
// Television sync source and glyph generator stand-in for the text unit
`timescale 1ns/1ps
module tv_sync_model #(
    parameter int LINE_CLKS = 256,
    parameter int FRAME_LINES = 32,
    parameter int VS_LINES = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] glyph_code,
    input wire logic glyph_bank,
    input wire logic [4:0] glyph_row,
    input wire logic [2:0] glyph_col,
    output logic glyph_pixel,
    output logic vsync,
    output logic hsync
);
    int dot;
    int line;
    // Dot pattern depends on every address bit so a wrong address shows
    assign glyph_pixel = ^{glyph_code, glyph_bank, glyph_row, glyph_col};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dot <= 0;
            line <= 0;
            vsync <= 1'b0;
            hsync <= 1'b0;
        end else begin
            dot <= (dot == LINE_CLKS - 1) ? 0 : dot + 1;
            if (dot == LINE_CLKS - 1) begin
                line <= (line == FRAME_LINES - 1) ? 0 : line + 1;
            end
            hsync <= (dot < 4);
            vsync <= (line < VS_LINES);
        end
    end
endmodule
